// ==== rtl/rtcs_pkg.sv ====
// Shared constants and types for the two-wire slave access path.
// Assumes the core clock runs at 100 MHz; link timing comes from bus edges only.
package rtcs_pkg;

	// ------------------------------------------------------------
	// Bus framing
	// ------------------------------------------------------------
	localparam logic [6:0] SLAVE_ADDR = 7'h32;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] PTR_RESET = 4'hF;
	localparam logic [3:0] FMT_READ_NOW = 4'h4;
	localparam logic [7:0] IDLE_READ_BYTE = 8'hFF;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 100000000;
	localparam int unsigned TIMEOUT_MS = 500;
	localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
	localparam logic [1:0] PEND_MAX = 2'h3;

	// ------------------------------------------------------------
	// Link state machine and byte roles
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX = 5'h02,
		ST_ACK = 5'h04,
		ST_TX = 5'h08,
		ST_TXACK = 5'h10
	} rtcs_lstate_t;

	typedef enum logic [1:0] {
		KIND_ADDR = 2'h0,
		KIND_PTR = 2'h1,
		KIND_DATA = 2'h2,
		KIND_READ = 2'h3
	} rtcs_kind_t;

endpackage

// ==== rtl/rtcs_sync.sv ====
// Two flip-flop synchroniser for levels entering a clock domain.
// Assumes each bit is an independent level; multi-bit values need a handshake.
`timescale 1ns/10ps
module rtcs_sync #(
	parameter int W = 1
) (
	input logic clk_in,
	input logic rst_in,
	input logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} rtcs_sync_t;

	rtcs_sync_t s_q;
	rtcs_sync_t s_d;

	// First stage feeds only the second stage
	always_comb begin
		s_d.s1 = d_in;
		s_d.s2 = s_q.s1;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q_out = s_q.s2;
endmodule

// ==== rtl/rtcs_xfer.sv ====
// Event-with-data crossing by toggle: the source flips a flag and holds the word.
// Assumes events are spaced by at least four destination clocks, so the held word
// is stable whenever the destination samples it.
`timescale 1ns/10ps
module rtcs_xfer #(
	parameter int W = 8
) (
	input logic src_clk_in,
	input logic src_rst_in,
	input logic src_valid_in,
	input logic [W-1:0] src_data_in,
	input logic dst_clk_in,
	input logic dst_rst_in,
	output logic dst_valid_out,
	output logic [W-1:0] dst_data_out
);
	typedef struct packed {
		logic tog;
		logic [W-1:0] data;
	} rtcs_xsrc_t;

	typedef struct packed {
		logic tog_p;
		logic valid;
		logic [W-1:0] data;
	} rtcs_xdst_t;

	rtcs_xsrc_t s_q;
	rtcs_xsrc_t s_d;
	rtcs_xdst_t d_q;
	rtcs_xdst_t d_d;
	logic tog_s;

	always_comb begin
		s_d = s_q;
		if (src_valid_in) begin
			s_d.tog = ~s_q.tog;
			s_d.data = src_data_in;
		end
	end

	always_ff @(posedge src_clk_in) begin
		if (src_rst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	rtcs_sync #(.W(1)) u_tog_sync (
		.clk_in(dst_clk_in),
		.rst_in(dst_rst_in),
		.d_in(s_q.tog),
		.q_out(tog_s)
	);

	// Word is sampled only after the flag has settled, never while it moves
	always_comb begin
		d_d = d_q;
		d_d.tog_p = tog_s;
		d_d.valid = tog_s ^ d_q.tog_p;
		if (tog_s ^ d_q.tog_p) begin
			d_d.data = s_q.data;
		end
	end

	always_ff @(posedge dst_clk_in) begin
		if (dst_rst_in) begin
			d_q <= '0;
		end else begin
			d_q <= d_d;
		end
	end

	assign dst_valid_out = d_q.valid;
	assign dst_data_out = d_q.data;
endmodule

// ==== rtl/rtcs_i2c_slave.sv ====
// Two-wire slave access path of a calendar clock: bus side on link_clk_in,
// register and time-base side on clk_in.
// Assumes raw open-drain pin levels and a link clock that oversamples SCL
// at least eight times per bus bit; registers answer reads in the same cycle.
`timescale 1ns/10ps
module rtcs_i2c_slave #(
	parameter int unsigned TIMEOUT_CYC = rtcs_pkg::TIMEOUT_CYC
) (
	input logic clk_in,
	input logic rst_in,
	input logic link_clk_in,
	input logic scl_in,
	input logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	output logic wr_valid_out,
	output logic [3:0] wr_addr_out,
	output logic [7:0] wr_data_out,
	output logic rd_req_out,
	output logic [3:0] rd_addr_out,
	input logic [7:0] rd_data_in,
	input logic carry_in,
	output logic carry_out,
	output logic hold_out
);
	import rtcs_pkg::*;

	// ------------------------------------------------------------
	// State of both domains
	// ------------------------------------------------------------
	typedef struct packed {
		logic scl_p;
		logic sda_p;
		rtcs_lstate_t st;
		rtcs_kind_t kind;
		logic [3:0] bits;
		logic [7:0] sh;
		logic ack_ok;
		logic [3:0] ptr;
		logic [3:0] fmt;
		logic active;
		logic locked;
		logic oe;
		logic sda_o;
		logic wr_go;
		logic [11:0] wr_word;
		logic rd_go;
		logic [3:0] rd_addr;
		logic [7:0] rd_byte;
	} rtcs_link_t;

	typedef struct packed {
		logic [31:0] tcnt;
		logic abort;
		logic hold;
		logic [1:0] pend;
		logic carry;
		logic wr_v;
		logic [3:0] wr_a;
		logic [7:0] wr_d;
		logic rd_req;
		logic [3:0] rd_a;
		logic rep_go;
		logic [7:0] rep_data;
	} rtcs_core_t;

	rtcs_link_t l_q;
	rtcs_link_t l_d;
	rtcs_core_t c_q;
	rtcs_core_t c_d;

	logic link_rst;
	logic [1:0] pins_s;
	logic scl_s;
	logic sda_s;
	logic abort_s;
	logic act_s;
	logic rep_valid;
	logic [7:0] rep_data;
	logic wr_valid_c;
	logic [11:0] wr_word_c;
	logic rdq_valid;
	logic [3:0] rdq_addr;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic [7:0] tx_byte;
	logic tx_after_ack;

	// ------------------------------------------------------------
	// Crossings
	// ------------------------------------------------------------
	// Reset reaches the link domain through its own synchroniser
	rtcs_sync #(.W(1)) u_rst_sync (
		.clk_in(link_clk_in),
		.rst_in(1'b0),
		.d_in(rst_in),
		.q_out(link_rst)
	);

	// Pins pass inverted, so a cleared synchroniser reads as an idle bus, not a false edge
	rtcs_sync #(.W(2)) u_pin_sync (
		.clk_in(link_clk_in),
		.rst_in(link_rst),
		.d_in({~scl_in, ~sda_in}),
		.q_out(pins_s)
	);

	rtcs_sync #(.W(1)) u_abort_sync (
		.clk_in(link_clk_in),
		.rst_in(link_rst),
		.d_in(c_q.abort),
		.q_out(abort_s)
	);

	rtcs_sync #(.W(1)) u_act_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.d_in(l_q.active),
		.q_out(act_s)
	);

	rtcs_xfer #(.W(12)) u_wr_xfer (
		.src_clk_in(link_clk_in),
		.src_rst_in(link_rst),
		.src_valid_in(l_q.wr_go),
		.src_data_in(l_q.wr_word),
		.dst_clk_in(clk_in),
		.dst_rst_in(rst_in),
		.dst_valid_out(wr_valid_c),
		.dst_data_out(wr_word_c)
	);

	rtcs_xfer #(.W(4)) u_rdq_xfer (
		.src_clk_in(link_clk_in),
		.src_rst_in(link_rst),
		.src_valid_in(l_q.rd_go),
		.src_data_in(l_q.rd_addr),
		.dst_clk_in(clk_in),
		.dst_rst_in(rst_in),
		.dst_valid_out(rdq_valid),
		.dst_data_out(rdq_addr)
	);

	rtcs_xfer #(.W(8)) u_rep_xfer (
		.src_clk_in(clk_in),
		.src_rst_in(rst_in),
		.src_valid_in(c_q.rep_go),
		.src_data_in(c_q.rep_data),
		.dst_clk_in(link_clk_in),
		.dst_rst_in(link_rst),
		.dst_valid_out(rep_valid),
		.dst_data_out(rep_data)
	);

	// ------------------------------------------------------------
	// Bus conditions
	// ------------------------------------------------------------
	assign scl_s = ~pins_s[1];
	assign sda_s = ~pins_s[0];
	assign scl_rise = scl_s && !l_q.scl_p;
	assign scl_fall = !scl_s && l_q.scl_p;
	assign bus_start = scl_s && l_q.scl_p && l_q.sda_p && !sda_s;
	assign bus_stop = scl_s && l_q.scl_p && !l_q.sda_p && sda_s;
	// After a timeout the stored data is no longer offered
	assign tx_byte = l_q.locked ? IDLE_READ_BYTE : l_q.rd_byte;
	assign tx_after_ack = (l_q.kind == KIND_READ) ||
		((l_q.kind == KIND_DATA) && (l_q.fmt == FMT_READ_NOW));

	// ------------------------------------------------------------
	// Link domain
	// ------------------------------------------------------------
	always_comb begin
		l_d = l_q;
		l_d.scl_p = scl_s;
		l_d.sda_p = sda_s;
		l_d.wr_go = 1'b0;
		l_d.rd_go = 1'b0;
		l_d.sda_o = 1'b0;
		if (rep_valid) begin
			l_d.rd_byte = rep_data;
		end
		// Timeout behaves like a stop but keeps following the bus framing
		if (abort_s && l_q.active) begin
			l_d.active = 1'b0;
			l_d.locked = 1'b1;
			l_d.ptr = PTR_RESET;
		end
		if (bus_stop) begin
			l_d.st = ST_IDLE;
			l_d.oe = 1'b0;
			l_d.active = 1'b0;
			l_d.locked = 1'b0;
			l_d.ptr = PTR_RESET;
		end else if (bus_start) begin
			// Repeated start re-enters address phase, transaction stays open
			l_d.st = ST_RX;
			l_d.kind = KIND_ADDR;
			l_d.bits = 4'h0;
			l_d.oe = 1'b0;
			if (!l_q.locked) begin
				l_d.active = 1'b1;
			end
		end else begin
			case (l_q.st)
				ST_RX: begin
					if (scl_rise) begin
						l_d.sh = {l_q.sh[6:0], sda_s};
						l_d.bits = l_q.bits + 4'h1;
					end else if (scl_fall && (l_q.bits == BYTE_BITS)) begin
						l_d.bits = 4'h0;
						case (l_q.kind)
							KIND_ADDR: begin
								if (l_q.sh[7:1] == SLAVE_ADDR) begin
									l_d.st = ST_ACK;
									l_d.oe = 1'b1;
									if (l_q.sh[0]) begin
										l_d.kind = KIND_READ;
										l_d.rd_go = 1'b1;
										l_d.rd_addr = l_q.ptr;
									end else begin
										l_d.kind = KIND_PTR;
									end
								end else begin
									l_d.st = ST_IDLE;
								end
							end
							KIND_PTR: begin
								if (l_q.locked) begin
									l_d.st = ST_IDLE;
								end else begin
									l_d.ptr = l_q.sh[7:4];
									l_d.fmt = l_q.sh[3:0];
									l_d.kind = KIND_DATA;
									l_d.st = ST_ACK;
									l_d.oe = 1'b1;
									if (l_q.sh[3:0] == FMT_READ_NOW) begin
										l_d.rd_go = 1'b1;
										l_d.rd_addr = l_q.sh[7:4];
									end
								end
							end
							KIND_DATA: begin
								if (l_q.locked) begin
									l_d.st = ST_IDLE;
								end else begin
									l_d.wr_go = 1'b1;
									l_d.wr_word = {l_q.ptr, l_q.sh};
									l_d.ptr = l_q.ptr + 4'h1;
									l_d.st = ST_ACK;
									l_d.oe = 1'b1;
								end
							end
							default: begin
								l_d.st = ST_IDLE;
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						// Release at the end of the ninth clock or go straight to sending
						l_d.oe = 1'b0;
						if (tx_after_ack) begin
							l_d.st = ST_TX;
							l_d.sh = tx_byte;
							l_d.oe = ~tx_byte[7];
							l_d.bits = 4'h1;
						end else begin
							l_d.st = ST_RX;
							l_d.bits = 4'h0;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (l_q.bits == BYTE_BITS) begin
							l_d.oe = 1'b0;
							l_d.st = ST_TXACK;
							l_d.ptr = l_q.ptr + 4'h1;
							l_d.rd_go = 1'b1;
							l_d.rd_addr = l_q.ptr + 4'h1;
						end else begin
							l_d.sh = {l_q.sh[6:0], 1'b0};
							l_d.oe = ~l_q.sh[6];
							l_d.bits = l_q.bits + 4'h1;
						end
					end
				end
				ST_TXACK: begin
					if (scl_rise) begin
						l_d.ack_ok = ~sda_s;
					end else if (scl_fall) begin
						if (l_q.ack_ok) begin
							l_d.st = ST_TX;
							l_d.sh = tx_byte;
							l_d.oe = ~tx_byte[7];
							l_d.bits = 4'h1;
						end else begin
							l_d.st = ST_IDLE;
						end
					end
				end
				ST_IDLE: begin
					l_d.oe = 1'b0;
				end
				default: begin
					l_d.st = ST_IDLE;
					l_d.oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk_in) begin
		if (link_rst) begin
			l_q <= '0;
			l_q.scl_p <= 1'b1;
			l_q.sda_p <= 1'b1;
			l_q.st <= ST_IDLE;
			l_q.kind <= KIND_ADDR;
			l_q.ptr <= PTR_RESET;
		end else begin
			l_q <= l_d;
		end
	end

	// ------------------------------------------------------------
	// Core domain
	// ------------------------------------------------------------
	always_comb begin
		c_d = c_q;
		c_d.hold = act_s && !c_q.abort;
		c_d.carry = 1'b0;
		c_d.wr_v = wr_valid_c;
		if (wr_valid_c) begin
			c_d.wr_a = wr_word_c[11:8];
			c_d.wr_d = wr_word_c[7:0];
		end
		c_d.rd_req = rdq_valid;
		if (rdq_valid) begin
			c_d.rd_a = rdq_addr;
		end
		c_d.rep_go = c_q.rd_req;
		if (c_q.rd_req) begin
			c_d.rep_data = rd_data_in;
		end
		// Carries pile up while held and drain one per cycle after release
		if (c_q.hold) begin
			if (carry_in && (c_q.pend != PEND_MAX)) begin
				c_d.pend = c_q.pend + 2'h1;
			end
		end else if (carry_in) begin
			c_d.carry = 1'b1;
		end else if (c_q.pend != 2'h0) begin
			c_d.carry = 1'b1;
			c_d.pend = c_q.pend - 2'h1;
		end
		// Counting is tied to the open transaction, so a repeated start cannot reset it
		if (!act_s) begin
			c_d.tcnt = 32'h0;
			c_d.abort = 1'b0;
		end else if (!c_q.abort) begin
			if (c_q.tcnt == 32'(TIMEOUT_CYC - 1)) begin
				c_d.abort = 1'b1;
			end else begin
				c_d.tcnt = c_q.tcnt + 32'h1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			c_q <= '0;
		end else begin
			c_q <= c_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign sda_out = l_q.sda_o;
	assign sda_oe_out = l_q.oe;
	assign wr_valid_out = c_q.wr_v;
	assign wr_addr_out = c_q.wr_a;
	assign wr_data_out = c_q.wr_d;
	assign rd_req_out = c_q.rd_req;
	assign rd_addr_out = c_q.rd_a;
	assign carry_out = c_q.carry;
	assign hold_out = c_q.hold;
endmodule

// ==== verification/rtcs_i2c_slave_asserts.sv ====
// Checker for the two-wire slave top ports, attached by bind below.
// Assumes reset is held long enough to reach the link domain.
`timescale 1ns/10ps
module rtcs_i2c_slave_asserts #(
	parameter int unsigned TIMEOUT_CYC = 2000
) (
	input logic clk_in,
	input logic rst_in,
	input logic link_clk_in,
	input logic scl_in,
	input logic sda_oe_out,
	input logic wr_valid_out,
	input logic [3:0] wr_addr_out,
	input logic [7:0] wr_data_out,
	input logic carry_in,
	input logic carry_out,
	input logic hold_out,
	input logic sda_out,
	input logic rd_req_out
);
	logic [1:0] pend_q;
	logic [31:0] hcnt_q;
	logic wseen_q;
	// --------
	// Helper state, cleared whenever no transaction is open
	// --------
	always_ff @(posedge clk_in) begin
		if (rst_in || !hold_out) begin
			pend_q <= 2'h0;
			hcnt_q <= 32'h0;
			wseen_q <= 1'b0;
		end else begin
			hcnt_q <= hcnt_q + 32'h1;
			wseen_q <= wseen_q | wr_valid_out;
			if (carry_in && pend_q != 2'h3) begin
				pend_q <= pend_q + 2'h1;
			end
		end
	end
	// --------
	// Assertions
	// --------
	sequence s_release;
		$fell(hold_out) && pend_q != 2'h0;
	endsequence
	sequence s_idle_carry;
		carry_in && !hold_out ##1 !hold_out;
	endsequence
	chk_wr_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_valid_out |=> !wr_valid_out) else $error("write strobe too long");
	chk_wr_hold: assert property (@(posedge clk_in) disable iff (rst_in)
		!wr_valid_out |-> $stable({wr_addr_out, wr_data_out})) else $error("write word moved");
	chk_wr_step: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_valid_out && wseen_q |-> wr_addr_out == $past(wr_addr_out) + 4'h1)
		else $error("write pointer not stepped");
	chk_carry_pass: assert property (@(posedge clk_in) disable iff (rst_in)
		s_idle_carry |-> carry_out) else $error("idle carry not passed");
	chk_carry_held: assert property (@(posedge clk_in) disable iff (rst_in)
		hold_out && $past(hold_out) |-> !carry_out) else $error("carry during hold");
	chk_carry_drain: assert property (@(posedge clk_in) disable iff (rst_in)
		s_release |-> ##[0:3] carry_out) else $error("held carry lost");
	chk_hold_bound: assert property (@(posedge clk_in) disable iff (rst_in)
		hcnt_q <= TIMEOUT_CYC + 8) else $error("hold outlived timeout");
	chk_oe_scl_low: assert property (@(posedge link_clk_in) disable iff (rst_in)
		$changed(sda_oe_out) |-> !scl_in) else $error("data moved with clock high");
	chk_rd_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
		rd_req_out |=> !rd_req_out) else $error("read strobe too long");
	chk_sda_drive: assert property (@(posedge link_clk_in) disable iff (rst_in)
		sda_oe_out |-> !sda_out) else $error("enabled data line not low");
endmodule

bind rtcs_i2c_slave rtcs_i2c_slave_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (
	.clk_in, .rst_in, .link_clk_in, .scl_in, .sda_oe_out, .wr_valid_out,
	.wr_addr_out, .wr_data_out, .carry_in, .carry_out, .hold_out, .sda_out, .rd_req_out
);

// ==== verification/rtcs_master_model.sv ====
// Two-wire bus master model: drives the clock line and its share of data.
// Assumes a pulled-up data wire; the device pull-down enable is fed back.
`timescale 1ns/10ps
module rtcs_master_model #(
	parameter int HP = 500
) (
	input wire logic sda_oe_in,
	output logic scl_out,
	output logic sda_out,
	output logic wire_out
);
	// Released line reads high through the pull-up
	assign wire_out = sda_out & ~sda_oe_in;
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// Data moves mid-low only, so no false start or stop is seen
	task automatic bit_io(input logic b, output logic r);
		#(HP / 2);
		sda_out = b;
		#(HP / 2);
		scl_out = 1'b1;
		#HP;
		r = wire_out;
		scl_out = 1'b0;
	endtask
	task automatic start();
		#(HP / 2);
		sda_out = 1'b1;
		#(HP / 2);
		scl_out = 1'b1;
		#HP;
		sda_out = 1'b0;
		#HP;
		scl_out = 1'b0;
	endtask
	task automatic stop();
		#(HP / 2);
		sda_out = 1'b0;
		#(HP / 2);
		scl_out = 1'b1;
		#HP;
		sda_out = 1'b1;
		#HP;
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic recv(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
endmodule

// ==== verification/rtcs_i2c_slave_bench.sv ====
// Self-checking bench: master model on the bus, address-pattern registers
// and carry pulses on the core side.
`timescale 1ns/10ps
module rtcs_i2c_slave_bench;
	import rtcs_pkg::*;
	localparam int unsigned TMO = 10000;
	logic clk_in, rst_in, link_clk_in, carry_in, oe_seen;
	logic scl, sda_m, sda_w, sda_oe, wr_valid, rd_req, carry_out, hold;
	logic [3:0] wr_addr, rd_addr;
	logic [7:0] wr_data;
	logic [11:0] wq[$];
	int n_mismatch = 0;
	int check_count = 0;
	int n_carry = 0;
	int cyc = 0;
	int c0, t0;
	rtcs_master_model mst_u (.sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda_m), .wire_out(sda_w));
	// Registers answer with a pattern of their own address
	rtcs_i2c_slave #(.TIMEOUT_CYC(TMO)) dut_u (
		.clk_in(clk_in), .rst_in(rst_in), .link_clk_in(link_clk_in),
		.scl_in(scl), .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe),
		.wr_valid_out(wr_valid), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
		.rd_req_out(rd_req), .rd_addr_out(rd_addr), .rd_data_in({~rd_addr, rd_addr}),
		.carry_in(carry_in), .carry_out(carry_out), .hold_out(hold)
	);
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	initial begin
		link_clk_in = 1'b0;
		#3;
		forever #24 link_clk_in = ~link_clk_in;
	end
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (wr_valid === 1'b1) begin
			wq.push_back({wr_addr, wr_data});
		end
		if (carry_out === 1'b1) begin
			n_carry <= n_carry + 1;
		end
		if (sda_oe === 1'b1) begin
			oe_seen <= 1'b1;
		end
	end
	task automatic chk(input string what, input logic [11:0] e, input logic [11:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic tx(input logic [7:0] d, input logic e);
		logic a;
		mst_u.send(d, a);
		chk("ack", {11'h0, e}, {11'h0, a});
	endtask
	task automatic rx(input logic last, input logic [7:0] e);
		logic [7:0] d;
		mst_u.recv(last, d);
		chk("read byte", {4'h0, e}, {4'h0, d});
	endtask
	task automatic rd_run(input logic [3:0] p, input int n);
		for (int i = 0; i < n; i++) begin
			rx(i == n - 1, {~p, p});
			p++;
		end
	endtask
	task automatic pulse_carry();
		@(posedge clk_in);
		carry_in <= 1'b1;
		@(posedge clk_in);
		carry_in <= 1'b0;
	endtask
	task automatic wait_hold(input logic v, input int lim);
		// Sampled mid-cycle, clear of the edge that moves the flag
		for (int k = 0; k < lim && hold !== v; k++) begin
			@(negedge clk_in);
		end
		if (hold !== v) begin
			n_mismatch++;
			$display("wrong value hold_out expected %h seen %h", v, hold);
			print_verdict();
		end
	endtask
	task automatic fin();
		mst_u.stop();
		wait_hold(1'b0, 400);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic t_carry_idle();
		c0 = n_carry;
		pulse_carry();
		repeat (3) @(posedge clk_in);
		chk("idle carry", 12'h1, 12'(n_carry - c0));
	endtask
	task automatic t_write();
		logic [11:0] ew[3] = '{12'hEA1, 12'hFB2, 12'h0C3};
		wq.delete();
		c0 = n_carry;
		mst_u.start();
		tx(8'h64, 1'b1);
		tx(8'hE0, 1'b1);
		tx(8'hA1, 1'b1);
		pulse_carry();
		pulse_carry();
		tx(8'hB2, 1'b1);
		tx(8'hC3, 1'b1);
		chk("held carry", 12'h0, 12'(n_carry - c0));
		fin();
		repeat (10) @(posedge clk_in);
		chk("freed carry", 12'h2, 12'(n_carry - c0));
		foreach (ew[i]) chk("write", ew[i], wq[i]);
	endtask
	task automatic t_read_sr();
		mst_u.start();
		tx(8'h64, 1'b1);
		tx(8'h20, 1'b1);
		mst_u.start();
		tx(8'h65, 1'b1);
		rd_run(4'h2, 3);
		fin();
	endtask
	task automatic t_read_fmt4();
		mst_u.start();
		tx(8'h64, 1'b1);
		tx(8'hE4, 1'b1);
		rd_run(4'hE, 3);
		fin();
	endtask
	task automatic t_read_plain();
		mst_u.start();
		tx(8'h65, 1'b1);
		rd_run(4'hF, 2);
		fin();
	endtask
	task automatic t_foreign();
		logic [7:0] fa[3] = '{8'h66, 8'hE5, 8'h62};
		wq.delete();
		oe_seen = 1'b0;
		foreach (fa[i]) begin
			mst_u.start();
			tx(fa[i], 1'b0);
			tx(8'h5A, 1'b0);
			fin();
		end
		chk("foreign drive", 12'h0, {10'h0, oe_seen, 1'b0});
		chk("foreign writes", 12'h0, 12'(wq.size()));
	endtask
	task automatic t_timeout();
		mst_u.start();
		t0 = cyc;
		tx(8'h64, 1'b1);
		repeat (TMO / 2) @(posedge clk_in);
		mst_u.start();
		tx(8'h64, 1'b1);
		wait_hold(1'b0, TMO);
		chk("abort time", 12'h1, {11'h0, cyc - t0 > TMO - 150 && cyc - t0 < TMO + 20});
		tx(8'h20, 1'b0);
		mst_u.start();
		tx(8'h65, 1'b1);
		rx(1'b1, IDLE_READ_BYTE);
		fin();
	endtask
	initial begin
		rst_in = 1'b1;
		carry_in = 1'b0;
		oe_seen = 1'b0;
		// Long reset so it reaches the link domain too
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (100) @(posedge clk_in);
		t_carry_idle();
		t_write();
		t_read_sr();
		t_read_fmt4();
		t_read_plain();
		t_foreign();
		t_timeout();
		t_read_plain();
		print_verdict();
	end
endmodule
